// >>> verilog/srd_shadow_region_decoder.sv
`include "srd_params.svh"

module srd_shadow_region_decoder
	import srd_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Wishbone register slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// CPU host bus pins
	input wire logic cpuCycleValid,
	input wire logic cpuCycleWrite,
	input wire logic [31:0] host_address_lines,
	// PCI-to-DRAM activity from the arbiter
	input wire logic pciDramBusy,
	// Decode result toward DRAM and PCI paths
	output srd_decode_type decode,
	// CPU hold and concurrency indication
	output logic cpuAddressHold,
	output logic concurrentL2
);

	srd_state_type state;
	srd_state_type next_state;
	srd_cpu_cycle_type pinCycle;
	logic busRequest;
	logic busWrite;
	logic [7:0] regIndex;
	logic [31:0] readData;
	logic shadowHit;
	logic shadowToDram;
	logic shadowCacheable;
	logic windowHit;
	logic windowSizeValid;
	logic windowEnable;

	// ****************************************************************
	// Pin sampling
	// ****************************************************************

	// Pins are asynchronous to mclk, so the whole cycle goes through two stages
	assign pinCycle.valid = cpuCycleValid;
	assign pinCycle.isWrite = cpuCycleWrite;
	assign pinCycle.address = host_address_lines;

	// ****************************************************************
	// Bus slave decode
	// ****************************************************************

	// A new request is one not already answered in the previous cycle
	assign busRequest = wb_cyc_i && wb_stb_i && !state.wbAck;
	assign busWrite = busRequest && wb_we_i;
	// Word addressing: the register index sits above the byte lanes
	assign regIndex = wb_adr_i[9:2];
	assign windowEnable = state.writeBufferOption[`SRD_FBEN_BIT];

	// ****************************************************************
	// Address classification
	// ****************************************************************

	// Shadow area lookup over all sixteen 16KB blocks
	srd_shadow_lookup shadowLookup (
		.address(state.sync2.address),
		.isWrite(state.sync2.isWrite),
		.readEnable({state.upperRead, state.lowerRead}),
		.writeEnable({state.upperWrite, state.lowerWrite}),
		.cacheEnable({state.upperCache, state.lowerCache}),
		.shadowHit(shadowHit),
		.toDram(shadowToDram),
		.cacheable(shadowCacheable)
	);

	// Frame buffer window bounds check
	srd_window_match windowMatch (
		.address(state.sync2.address),
		.window(state.frameBufferWindow),
		.hit(windowHit),
		.sizeValid(windowSizeValid)
	);

	// ****************************************************************
	// Register read multiplexer
	// ****************************************************************

	// Unmapped indices and the reserved byte read as zero
	always_comb begin
		readData = 32'h0000_0000;
		case (regIndex)
			`SRD_IDX_LOWER_READ: begin
				readData[7:0] = state.lowerRead;
			end
			`SRD_IDX_UPPER_READ: begin
				readData[7:0] = state.upperRead;
			end
			`SRD_IDX_LOWER_WRITE: begin
				readData[7:0] = state.lowerWrite;
			end
			`SRD_IDX_UPPER_WRITE: begin
				readData[7:0] = state.upperWrite;
			end
			`SRD_IDX_LOWER_CACHE: begin
				readData[7:0] = state.lowerCache;
			end
			`SRD_IDX_UPPER_CACHE: begin
				readData[7:0] = state.upperCache;
			end
			`SRD_IDX_STRAP_CTRL: begin
				// Latched strap values show the captured board setup
				readData[`SRD_SRAM_MSB:`SRD_SRAM_LSB] = state.sramConfig;
				readData[`SRD_FREQ_MSB:`SRD_FREQ_LSB] = state.busFrequency;
				readData[`SRD_CONC_BIT] = state.concurrency;
			end
			`SRD_IDX_FB_WINDOW: begin
				readData[15:0] = state.frameBufferWindow;
			end
			`SRD_IDX_WB_OPTION: begin
				readData[7:0] = state.writeBufferOption;
			end
			default: begin
				readData = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************

	always_comb begin
		next_state = state;

		// Synchronisers run through reset so the straps see settled pins
		next_state.sync1 = pinCycle;
		next_state.sync2 = state.sync1;

		if (!reset_n) begin
			next_state.lowerRead = `SRD_RST_BYTE;
			next_state.upperRead = `SRD_RST_BYTE;
			next_state.lowerWrite = `SRD_RST_BYTE;
			next_state.upperWrite = `SRD_RST_BYTE;
			next_state.lowerCache = `SRD_RST_BYTE;
			next_state.upperCache = `SRD_RST_BYTE;
			// A literal cannot be bit-selected, so the reset bit is shifted down
			next_state.concurrency = 1'(`SRD_RST_STRAP >> `SRD_CONC_BIT);
			next_state.frameBufferWindow = `SRD_RST_FB;
			next_state.writeBufferOption = `SRD_RST_BYTE;
			next_state.wbAck = 1'b0;
			next_state.wbData = 32'h0000_0000;
			next_state.decode = '0;
			next_state.cpuAddressHold = 1'b0;
			next_state.concurrentL2 = 1'b0;
			// Straps follow the pins for as long as reset is held
			next_state.sramConfig =
				state.sync2.address[`SRD_STRAP_SRAM_MSB:`SRD_STRAP_SRAM_LSB];
			next_state.busFrequency =
				state.sync2.address[`SRD_STRAP_FREQ_MSB:`SRD_STRAP_FREQ_LSB];
		end else begin
			// Single-cycle answer; ack drops the cycle after it rose
			next_state.wbAck = busRequest;
			if (busRequest) begin
				next_state.wbData = readData;
			end

			// Byte registers live in lane 0, the window in lanes 1..0
			if (busWrite && wb_sel_i[0]) begin
				case (regIndex)
					`SRD_IDX_LOWER_READ: begin
						next_state.lowerRead = wb_dat_i[7:0];
					end
					`SRD_IDX_UPPER_READ: begin
						next_state.upperRead = wb_dat_i[7:0];
					end
					`SRD_IDX_LOWER_WRITE: begin
						next_state.lowerWrite = wb_dat_i[7:0];
					end
					`SRD_IDX_UPPER_WRITE: begin
						next_state.upperWrite = wb_dat_i[7:0];
					end
					`SRD_IDX_LOWER_CACHE: begin
						next_state.lowerCache = wb_dat_i[7:0];
					end
					`SRD_IDX_UPPER_CACHE: begin
						next_state.upperCache = wb_dat_i[7:0];
					end
					`SRD_IDX_STRAP_CTRL: begin
						// Strap bits are read-only; only the enable is taken
						next_state.concurrency = wb_dat_i[`SRD_CONC_BIT];
					end
					`SRD_IDX_FB_WINDOW: begin
						next_state.frameBufferWindow[7:0] = wb_dat_i[7:0];
					end
					`SRD_IDX_WB_OPTION: begin
						next_state.writeBufferOption = wb_dat_i[7:0];
					end
					default: begin
						next_state.concurrency = state.concurrency;
					end
				endcase
			end
			if (busWrite && wb_sel_i[1] && (regIndex == `SRD_IDX_FB_WINDOW)) begin
				next_state.frameBufferWindow[15:8] = wb_dat_i[15:8];
			end

			// Classify the settled CPU cycle one stage after the synchroniser
			next_state.decode.valid = state.sync2.valid;
			next_state.decode.isWrite = state.sync2.isWrite;
			next_state.decode.shadowHit = state.sync2.valid && shadowHit;
			next_state.decode.toDram = state.sync2.valid && shadowToDram;
			next_state.decode.cacheable = state.sync2.valid && shadowCacheable;
			// Window hits need the enable; reserved size codes never match,
			// and posting needs a write on top of the hit
			next_state.decode.frameBufferHit =
				state.sync2.valid && windowEnable && windowHit;
			next_state.decode.postedWrite = state.sync2.valid && state.sync2.isWrite
				&& windowEnable && windowHit && windowSizeValid;

			// Hold the CPU off while PCI owns DRAM, unless concurrency is on
			next_state.cpuAddressHold = pciDramBusy && !state.concurrency;
			next_state.concurrentL2 = pciDramBusy && state.concurrency;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Reset is folded into the next-state logic, which keeps it synchronous
	always_ff @(posedge mclk) begin
		state <= next_state;
	end

	// ****************************************************************
	// Outputs, each straight from a flip-flop
	// ****************************************************************
	assign wb_ack_o = state.wbAck;
	assign wb_dat_o = state.wbData;
	assign decode = state.decode;
	assign cpuAddressHold = state.cpuAddressHold;
	assign concurrentL2 = state.concurrentL2;

endmodule // srd_shadow_region_decoder

// >>> shared/srd_params.svh
`ifndef SRD_PARAMS_SVH
`define SRD_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SRD_IDX_LOWER_READ 8'h4C
`define SRD_IDX_UPPER_READ 8'h4D
`define SRD_IDX_LOWER_WRITE 8'h4E
`define SRD_IDX_UPPER_WRITE 8'h4F
`define SRD_IDX_LOWER_CACHE 8'h50
`define SRD_IDX_UPPER_CACHE 8'h51
`define SRD_IDX_STRAP_CTRL 8'h52
`define SRD_IDX_RESERVED 8'h53
`define SRD_IDX_FB_WINDOW 8'h54
`define SRD_IDX_WB_OPTION 8'h56

// ****************************************************************
// Reset values
// ****************************************************************
`define SRD_RST_BYTE 8'h00
`define SRD_RST_STRAP 8'hF0
`define SRD_RST_FB 16'hFFFF

// ****************************************************************
// Field positions
// ****************************************************************
`define SRD_CONC_BIT 0
`define SRD_FREQ_LSB 1
`define SRD_FREQ_MSB 2
`define SRD_SRAM_LSB 3
`define SRD_SRAM_MSB 7
`define SRD_FBEN_BIT 0
`define SRD_FB_BASE_LSB 4
`define SRD_FB_BASE_MSB 15
`define SRD_FB_SIZE_MSB 2
`define SRD_STRAP_SRAM_MSB 31
`define SRD_STRAP_SRAM_LSB 27
`define SRD_STRAP_FREQ_MSB 26
`define SRD_STRAP_FREQ_LSB 25

// ****************************************************************
// Address decode constants
// ****************************************************************
`define SRD_AREA_LSB 18
`define SRD_SHADOW_AREA 14'h0003
`define SRD_BLOCK_MSB 17
`define SRD_BLOCK_LSB 14
`define SRD_MB_LSB 20
`define SRD_MAX_SIZE_CODE 3'h4
`define SRD_BLOCKS 16

`endif

// >>> shared/srd_pkg.sv
package srd_pkg;

	// ****************************************************************
	// CPU memory cycle as seen on the host pins
	// ****************************************************************
	typedef struct packed {
		logic valid;
		logic isWrite;
		logic [31:0] address;
	} srd_cpu_cycle_type;

	// ****************************************************************
	// Classification of one CPU memory cycle
	// ****************************************************************
	typedef struct packed {
		logic valid;
		logic isWrite;
		logic shadowHit;
		logic toDram;
		logic cacheable;
		logic frameBufferHit;
		logic postedWrite;
	} srd_decode_type;

	// ****************************************************************
	// Whole state of the decoder
	// ****************************************************************
	typedef struct packed {
		srd_cpu_cycle_type sync1;
		srd_cpu_cycle_type sync2;
		logic [7:0] lowerRead;
		logic [7:0] upperRead;
		logic [7:0] lowerWrite;
		logic [7:0] upperWrite;
		logic [7:0] lowerCache;
		logic [7:0] upperCache;
		logic [4:0] sramConfig;
		logic [1:0] busFrequency;
		logic concurrency;
		logic [15:0] frameBufferWindow;
		logic [7:0] writeBufferOption;
		logic wbAck;
		logic [31:0] wbData;
		srd_decode_type decode;
		logic cpuAddressHold;
		logic concurrentL2;
	} srd_state_type;

endpackage

// >>> verilog/srd_shadow_lookup.sv
`include "srd_params.svh"

module srd_shadow_lookup
	import srd_pkg::*;
(
	// Cycle under decode
	input wire logic [31:0] address,
	input wire logic isWrite,
	// Per-block enables, lower area in bits 7..0
	input wire logic [15:0] readEnable,
	input wire logic [15:0] writeEnable,
	input wire logic [15:0] cacheEnable,
	// Classification
	output logic shadowHit,
	output logic toDram,
	output logic cacheable
);

	logic inArea;
	logic [15:0] blockHit;
	logic [15:0] dramHit;
	logic [15:0] cacheHit;

	// ****************************************************************
	// One 16KB block per entry, C0000h upward
	// ****************************************************************
	assign inArea = address[31:`SRD_AREA_LSB] == `SRD_SHADOW_AREA;

	genvar i;
	generate
		for (i = 0; i < `SRD_BLOCKS; i++) begin : gBlock
			// Block select from address bits of the 16KB granule
			assign blockHit[i] = inArea && (address[`SRD_BLOCK_MSB:`SRD_BLOCK_LSB] == 4'(i));
			// Reads and writes steer on separate enables
			assign dramHit[i] = blockHit[i] && (isWrite ? writeEnable[i] : readEnable[i]);
			// Cacheable only when the block is also read-shadowed
			assign cacheHit[i] = blockHit[i] && cacheEnable[i] && readEnable[i];
		end
	endgenerate

	// Only one block can hit, so an OR is a clean select
	assign shadowHit = |blockHit;
	assign toDram = |dramHit;
	assign cacheable = |cacheHit;

endmodule // srd_shadow_lookup

// >>> verilog/srd_window_match.sv
`include "srd_params.svh"

module srd_window_match
	import srd_pkg::*;
(
	// Cycle under decode
	input wire logic [31:0] address,
	// Window register contents
	input wire logic [15:0] window,
	// Match result
	output logic hit,
	output logic sizeValid
);

	logic [11:0] base;
	logic [2:0] sizeCode;
	logic [12:0] span;
	logic [12:0] limit;

	// ****************************************************************
	// Window bounds in 1MB units
	// ****************************************************************
	assign base = window[`SRD_FB_BASE_MSB:`SRD_FB_BASE_LSB];
	assign sizeCode = window[`SRD_FB_SIZE_MSB:0];
	assign sizeValid = sizeCode <= `SRD_MAX_SIZE_CODE;
	assign span = 13'h0001 << sizeCode;
	// Carry bit kept so a window at the top of 4GB does not wrap
	assign limit = {1'b0, base} + span;
	// Reserved size codes never match
	assign hit = sizeValid && (address[31:`SRD_MB_LSB] >= base)
		&& ({1'b0, address[31:`SRD_MB_LSB]} < limit);

endmodule // srd_window_match

// >>> testbench/srd_shadow_region_decoder_props.sv
module srd_shadow_region_decoder_props
	import srd_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Host side and decode
	input wire logic cpuCycleValid,
	input wire logic cpuCycleWrite,
	input wire logic [31:0] host_address_lines,
	input wire logic pciDramBusy,
	input wire srd_decode_type decode,
	input wire logic cpuAddressHold,
	input wire logic concurrentL2
);
	timeunit 1ns;
	timeprecision 1ns;
	// *****
	// Edges since release; decode checks wait for the sync pipe to refill
	// *****
	logic [1:0] upCnt;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			upCnt <= 2'h0;
		end else if (upCnt != 2'h3) begin
			upCnt <= upCnt + 2'h1;
		end
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	hold_busy_a: assert property (pciDramBusy |=> cpuAddressHold != concurrentL2)
		else $error("busy gives neither or both of hold and concurrency");
	hold_idle_a: assert property (!pciDramBusy |=> !cpuAddressHold && !concurrentL2)
		else $error("hold or concurrency without busy");
	posted_write_a: assert property (decode.postedWrite |-> decode.valid && decode.isWrite
		&& decode.frameBufferHit)
		else $error("posted write outside window write");
	decode_delay_a: assert property (upCnt == 2'h3 |-> decode.valid == $past(cpuCycleValid, 3)
		&& decode.isWrite == $past(cpuCycleWrite, 3))
		else $error("decode not three edges after pins");
	shadow_area_a: assert property (upCnt == 2'h3 && decode.valid |->
		decode.shadowHit == ($past(host_address_lines[31:18], 3) == 14'h0003))
		else $error("shadow hit wrong for address");
	cache_area_a: assert property (decode.cacheable |-> decode.shadowHit)
		else $error("cacheable outside shadow area");
endmodule // srd_shadow_region_decoder_props

// >>> testbench/srd_cpu_model.sv
module srd_cpu_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Requests from the bench
	input wire logic go,
	input wire logic goWrite,
	input wire logic [31:0] goAddress,
	input wire logic [6:0] strap,
	// Host pins
	output logic cpuCycleValid,
	output logic cpuCycleWrite,
	output logic [31:0] host_address_lines
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] left;
	// A cycle holds its pins five edges; a released bus keeps no value, so lines flip
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			left <= 3'h0;
			cpuCycleValid <= 1'b0;
			cpuCycleWrite <= 1'b0;
			host_address_lines <= {strap, 25'h0};
		end else if (go) begin
			left <= 3'h5;
			cpuCycleValid <= 1'b1;
			cpuCycleWrite <= goWrite;
			host_address_lines <= goAddress;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
		end else begin
			cpuCycleValid <= 1'b0;
			cpuCycleWrite <= ~cpuCycleWrite;
			host_address_lines <= ~host_address_lines;
		end
	end
endmodule // srd_cpu_model

// >>> testbench/srd_shadow_region_decoder_tb.sv
module srd_shadow_region_decoder_tb
	import srd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// *****
	// Bench state
	// *****
	logic mclk, reset_n, wbCyc, wbStb, wbWe, wbAck, cpuValid, cpuWrite;
	logic pciDramBusy, hold, concL2, go, goWrite;
	logic [3:0] wbSel;
	logic [6:0] strap;
	logic [11:0] off;
	logic [31:0] wbAdr, wbDatIn, wbDatOut, hostLines, goAddress, rnd, rdv, addr;
	logic [7:0] regs [8'h4c:8'h57];
	srd_decode_type decode;
	int errors, check_count;
	srd_shadow_region_decoder uut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatIn), .wb_dat_o(wbDatOut), .wb_ack_o(wbAck), .cpuCycleValid(cpuValid),
		.cpuCycleWrite(cpuWrite), .host_address_lines(hostLines), .pciDramBusy(pciDramBusy),
		.decode(decode), .cpuAddressHold(hold), .concurrentL2(concL2));
	srd_cpu_model cpu_i (.mclk(mclk), .reset_n(reset_n), .go(go), .goWrite(goWrite),
		.goAddress(goAddress), .strap(strap), .cpuCycleValid(cpuValid),
		.cpuCycleWrite(cpuWrite), .host_address_lines(hostLines));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] model_read(input logic [7:0] i);
		if (i < 8'h4c || i > 8'h57 || i inside {8'h53, 8'h55, 8'h57})
			return 32'h0;
		if (i == 8'h52)
			return {24'h0, strap, regs[i][0]};
		if (i == 8'h54)
			return {16'h0, regs[8'h55], regs[8'h54]};
		return {24'h0, regs[i]};
	endfunction
	function automatic srd_decode_type expect_decode(input logic [31:0] a, input logic w);
		srd_decode_type d;
		logic [15:0] rd, wen, ca;
		logic [12:0] base;
		logic [12:0] top;
		rd = {regs[8'h4d], regs[8'h4c]};
		wen = {regs[8'h4f], regs[8'h4e]};
		ca = {regs[8'h51], regs[8'h50]};
		base = {1'b0, regs[8'h55], regs[8'h54][7:4]};
		top = {1'b0, a[31:20]};
		d.valid = 1'b1;
		d.isWrite = w;
		d.shadowHit = a[31:18] == 14'h0003;
		d.toDram = d.shadowHit && (w ? wen[a[17:14]] : rd[a[17:14]]);
		d.cacheable = d.shadowHit && ca[a[17:14]] && rd[a[17:14]];
		d.frameBufferHit = regs[8'h56][0] && regs[8'h54][2:0] <= 3'h4 && top >= base
			&& top < base + (13'h1 << regs[8'h54][2:0]);
		d.postedWrite = w && d.frameBufferHit;
		return d;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, want);
		end
	endtask
	// One classic cycle, held until ack is seen at an edge
	task automatic bus(input logic we, input logic [7:0] i, input logic [31:0] d,
		input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge mclk);
		{wbCyc, wbStb, wbWe, wbSel} <= {2'h3, we, sel};
		wbAdr <= {22'h0, i, 2'h0};
		wbDatIn <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		chk({31'h0, wbAck}, 32'h1);
		rdv = wbDatOut;
		{wbCyc, wbStb} <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] v, input logic [1:0] sel);
		bus(1'b1, i, {16'h0, v}, {2'h0, sel});
		// Index 55h is not a register of its own: lane 1 of 54h is the only way in
		if (sel[0] && i != 8'h55 && i >= 8'h4c && i <= 8'h57)
			regs[i] = v[7:0];
		if (sel[1] && i == 8'h54)
			regs[8'h55] = v[15:8];
	endtask
	task automatic read_all();
		for (int i = 8'h4c; i <= 8'h60; i++) begin
			bus(1'b0, i[7:0], 32'h0, 4'hf);
			chk(rdv, model_read(i[7:0]));
		end
	endtask
	task automatic do_reset();
		reset_n <= 1'b0;
		strap <= rnd[6:0];
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		foreach (regs[i])
			regs[i] = 8'h00;
		{regs[8'h55], regs[8'h54]} = 16'hffff;
	endtask
	// Pins need three edges through the sync pipe before decode shows them
	task automatic cpu(input logic [31:0] a, input logic w);
		@(posedge mclk);
		{go, goWrite, goAddress} <= {1'b1, w, a};
		@(posedge mclk);
		go <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 chk(decode, expect_decode(a, w));
		repeat (2) @(posedge mclk);
	endtask
	task automatic give_verdict();
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Watchdog sized well past the whole sequence
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		give_verdict();
	end
	initial begin
		{reset_n, wbCyc, wbStb, wbWe, go, goWrite, pciDramBusy} = 7'h00;
		{wbSel, wbAdr, wbDatIn, goAddress} = 100'h0;
		{errors, check_count} = 64'h0;
		rnd = 32'h4fe6;
		do_reset();
		read_all();
		wr(8'h52, 16'hffff, 2'h3);
		wr(8'h53, 16'hffff, 2'h3);
		wr(8'h60, 16'hffff, 2'h3);
		repeat (30) begin
			rnd = xs(rnd);
			wr(8'h4c + 8'(rnd[7:0] % 8'h0c), rnd[23:8], rnd[25:24]);
		end
		read_all();
		// Every size code, window edges and random shadow traffic
		for (int c = 0; c < 8; c++) begin
			rnd = xs(rnd);
			wr(8'h54, {1'b1, rnd[10:0], rnd[12], 3'(c)}, 2'h3);
			wr(8'h56, {8'h00, rnd[20:13]}, 2'h1);
			for (int k = 0; k < 8; k++) begin
				rnd = xs(rnd);
				wr(8'h4c + 8'(k % 6), {8'h00, rnd[7:0]}, 2'h1);
				rnd = xs(rnd);
				off = k == 0 ? 12'hfff : k == 1 ? 12'h000 : 12'(1 << c) - 12'(k == 2);
				addr = {regs[8'h55], regs[8'h54][7:4]} + off;
				addr = k < 4 ? {addr[11:0], rnd[19:0]} : {14'h0003, rnd[17:0]};
				pciDramBusy <= rnd[30];
				cpu(rnd[31] && k > 5 ? rnd : addr, rnd[29]);
			end
		end
		for (int c = 0; c < 2; c++) begin
			wr(8'h52, 16'(c), 2'h1);
			pciDramBusy <= 1'b1;
			@(posedge mclk);
			#1 chk({hold, concL2}, c ? 32'h1 : 32'h2);
			@(posedge mclk);
			pciDramBusy <= 1'b0;
		end
		rnd = xs(rnd);
		do_reset();
		read_all();
		give_verdict();
	end
endmodule // srd_shadow_region_decoder_tb
bind srd_shadow_region_decoder srd_shadow_region_decoder_props props_i (.mclk(mclk),
	.reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.cpuCycleValid(cpuCycleValid), .cpuCycleWrite(cpuCycleWrite),
	.host_address_lines(host_address_lines), .pciDramBusy(pciDramBusy), .decode(decode),
	.cpuAddressHold(cpuAddressHold), .concurrentL2(concurrentL2));
